// ### verilog/cmp_pkg.sv
// Shared constants and types for the comparator sleep and reset controller.
package cmp_pkg;

    // =====================================================================
    // Register bus geometry and byte offsets
    // =====================================================================
    localparam int unsigned CMP_ADR_W      = 8;
    localparam int unsigned CMP_DAT_W      = 32;
    localparam logic [7:0]  CMP_OFF_CONFIG = 8'h00;
    localparam logic [7:0]  CMP_OFF_AUX    = 8'h04;
    localparam logic [7:0]  CMP_OFF_PFLAG  = 8'h08;
    localparam logic [7:0]  CMP_OFF_ICTRL  = 8'h0C;
    localparam logic [7:0]  CMP_OFF_ISTAT  = 8'h10;
    localparam logic [7:0]  CMP_OFF_IMASK  = 8'h14;
    localparam logic [7:0]  CMP_OFF_STATUS = 8'h18;

    // =====================================================================
    // Configuration register layout and reset values
    // =====================================================================
    localparam int unsigned CMP_CFG_RESULT = 6;
    localparam int unsigned CMP_CFG_POL    = 4;
    localparam int unsigned CMP_CFG_SWITCH = 3;
    localparam int unsigned CMP_CFG_MODE   = 0;
    localparam int unsigned CMP_MODE_W     = 3;
    localparam logic [7:0]  CMP_CFG_WMASK  = 8'h1F;
    localparam logic [7:0]  CMP_CFG_RESET  = 8'h00;
    localparam logic [7:0]  CMP_AUX_RESET  = 8'h00;
    localparam logic [2:0]  CMP_MODE_OFF_A = 3'h0;
    localparam logic [2:0]  CMP_MODE_OFF_B = 3'h7;

    // =====================================================================
    // Interrupt control bits, event bits and their reset values
    // =====================================================================
    localparam int unsigned CMP_ICTRL_CIE  = 0;
    localparam int unsigned CMP_ICTRL_PER  = 1;
    localparam int unsigned CMP_ICTRL_GLB  = 2;
    localparam int unsigned CMP_ICTRL_W    = 3;
    localparam logic [2:0]  CMP_ICTRL_RST  = 3'h0;
    localparam int unsigned CMP_EV_CHANGE  = 0;
    localparam int unsigned CMP_EV_WAKE    = 1;
    localparam int unsigned CMP_EV_W       = 2;
    localparam logic [1:0]  CMP_EV_RESET   = 2'h0;

    // =====================================================================
    // Instruction phase divider: four system clocks per instruction cycle
    // =====================================================================
    localparam int unsigned CMP_Q_PHASES   = 4;
    localparam int unsigned CMP_Q1_INDEX   = 0;

    // =====================================================================
    // Core sequencing states
    // =====================================================================
    typedef enum logic [3:0] {
        CMP_RUN      = 4'b0001,
        CMP_SLEEP    = 4'b0010,
        CMP_POSTWAKE = 4'b0100,
        CMP_VECTOR   = 4'b1000
    } cmp_core_state_t;

endpackage

// ### verilog/cmp_sync.sv
// Two-stage synchroniser for a single asynchronous level.
`timescale 1ns/1ps

module cmp_sync
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rstn,
    // Asynchronous level in, synchronised level out.
    input  wire logic async_i,
    output logic      sync_o
);

    logic meta_r;
    logic sync_r;

    // The first stage is read by the second stage only.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else
        begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule

// ### verilog/cmp_sleep_ctrl.sv
// Comparator control: configuration, change detection, sleep wake and reset.
//
// Operation
// R1 - The change flag is set whenever the Q1 sample of the output differs from the reference.
// R2 - Any configuration read or write reloads the reference; a live mismatch blocks flag clears.
// R3 - A comparator change that lands exactly on a configuration read may go unflagged.
// R4 - Software waits about 1 us after enabling, clears mismatch and flags, then enables irqs.
// R5 - An enabled comparator keeps sampling and detecting changes throughout Sleep.
// R6 - Mode values 000 and 111 switch the comparator off for minimum power.
// R7 - A change wakes the core on comparator and peripheral enables alone, not the global one.
// R8 - After a wake the core first executes the instruction that follows the sleep instruction.
// R9 - After that instruction the core vectors to the handler only when the global enable is set.
// R10 - Any reset returns both comparator registers to their reset values, mode 000.
// R11 - Reset mode makes every comparator pin analog, buffers off, and disables the comparator.
// R12 - Config bits 7 and 5 read zero, 6 is the read-only output, 4 polarity, 3 switch, 2-0 mode.
// R13 - The asynchronous comparator output passes a two-stage synchroniser before the Q1 latch.
`timescale 1ns/1ps

module cmp_sleep_ctrl
    import cmp_pkg::*;
#(
    parameter int unsigned Q_PHASES = cmp_pkg::CMP_Q_PHASES
)
(
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // Classic Wishbone slave.
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [cmp_pkg::CMP_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [cmp_pkg::CMP_DAT_W-1:0] wb_dat_i,
    output logic      [cmp_pkg::CMP_DAT_W-1:0] wb_dat_o,
    output logic                               wb_ack_o,
    // Analog comparator side.
    input  wire logic                          comparator_raw,
    output logic                               comparator_enable,
    output logic                               pin_analog,
    output logic                               input_switch_select,
    output logic                               output_polarity,
    output logic                               comparator_result,
    // Core sequencing side.
    input  wire logic                          sleep_req,
    input  wire logic                          instr_done,
    output logic                               sleeping,
    output logic                               exec_next,
    output logic                               vector_isr,
    output logic                               isr_req,
    // Interrupt line.
    output logic                               irq
);

    import cmp_pkg::*;

    // =====================================================================
    // Parameter check
    // =====================================================================
    if (Q_PHASES < 2 || Q_PHASES > 16)
    begin : g_bad_q
        $error("Q_PHASES must lie between 2 and 16.");
    end

    // =====================================================================
    // Declarations
    // =====================================================================
    logic [3:0]             q_cnt_r;
    logic                   q1_en;
    logic                   comp_sync;
    logic                   sample_r;
    logic                   ref_r;
    logic [7:0]             cfg_r;
    logic [7:0]             aux_r;
    logic                   flag_r;
    logic [CMP_ICTRL_W-1:0] ictrl_r;
    logic [CMP_EV_W-1:0]    istat_r;
    logic [CMP_EV_W-1:0]    imask_r;
    cmp_core_state_t        state_r;
    cmp_core_state_t        state_nxt;
    logic                   ack_r;
    logic [31:0]            rdat_r;
    logic                   comp_en_r;
    logic                   pin_analog_r;
    logic                   switch_r;
    logic                   pol_r;
    logic                   result_r;
    logic                   sleeping_r;
    logic                   exec_next_r;
    logic                   vector_r;
    logic                   isr_req_r;
    logic                   irq_r;

    // =====================================================================
    // Instruction phase divider
    // =====================================================================
    // Counts system clocks within one instruction cycle.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            q_cnt_r <= 4'h0;
        else if (q_cnt_r == 4'(Q_PHASES - 1))
            q_cnt_r <= 4'h0;
        else
            q_cnt_r <= q_cnt_r + 4'h1;
    end

    assign q1_en = (q_cnt_r == 4'(CMP_Q1_INDEX));

    // =====================================================================
    // Comparator input path
    // =====================================================================
    // The analog result is asynchronous to clk and is synchronised first.
    cmp_sync u_sync
    (
        .clk     (clk),
        .rstn    (rstn),
        .async_i (comparator_raw),
        .sync_o  (comp_sync)
    ); // [R13]

    // Mode decode, polarity and the live output seen by the mismatch logic.
    wire [2:0] mode       = cfg_r[CMP_CFG_MODE +: CMP_MODE_W];
    wire       mode_off   = (mode == CMP_MODE_OFF_A) || (mode == CMP_MODE_OFF_B); // [R6]
    wire       mode_reset = (mode == CMP_MODE_OFF_A);
    wire       live_out   = !mode_off && (comp_sync ^ cfg_r[CMP_CFG_POL]);

    // =====================================================================
    // Register bus decode
    // =====================================================================
    wire       wb_req   = wb_cyc_i && wb_stb_i && !ack_r;
    wire       wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
    wire       hit_cfg  = (wb_adr_i == CMP_OFF_CONFIG);
    wire       hit_aux  = (wb_adr_i == CMP_OFF_AUX);
    wire       hit_pf   = (wb_adr_i == CMP_OFF_PFLAG);
    wire       hit_ic   = (wb_adr_i == CMP_OFF_ICTRL);
    wire       hit_is   = (wb_adr_i == CMP_OFF_ISTAT);
    wire       hit_im   = (wb_adr_i == CMP_OFF_IMASK);
    wire       hit_st   = (wb_adr_i == CMP_OFF_STATUS);
    // Every configuration access, read or write, touches the reference latch.
    wire       cfg_acc  = wb_req && hit_cfg; // [R2]
    wire [7:0] wbyte    = wb_dat_i[7:0];

    // Configuration byte as software sees it: bits 7 and 5 read zero.
    wire [7:0] cfg_view = {1'b0, sample_r, 1'b0, cfg_r[4:0]}; // [R12]

    // =====================================================================
    // Change detection
    // =====================================================================
    wire mismatch  = (sample_r != ref_r);
    wire flag_set  = mismatch; // [R1]
    wire flag_wr   = wb_wr && hit_pf;
    wire flag_next = flag_set || (flag_wr ? wbyte[0] : flag_r); // [R2]
    wire change_ev = flag_set && !flag_r;

    // Sampling latch on every Q1; Sleep does not stop it.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            sample_r <= 1'b0;
        else if (q1_en)
            sample_r <= live_out; // [R1] [R5]
    end

    // Reference latch reloads from the current output on any configuration access.
    // A change arriving with the access is absorbed and may go unflagged.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ref_r <= 1'b0;
        else if (cfg_acc)
            ref_r <= live_out; // [R2] [R3]
    end

    // Change flag: hardware set wins over a software clear.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flag_r <= 1'b0;
        else
            flag_r <= flag_next; // [R2]
    end

    // =====================================================================
    // Software registers
    // =====================================================================
    // Configuration and auxiliary registers return to reset on any reset.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_r <= CMP_CFG_RESET; // [R10]
            aux_r <= CMP_AUX_RESET; // [R10]
        end
        else
        begin
            if (wb_wr && hit_cfg)
                cfg_r <= wbyte & CMP_CFG_WMASK; // [R12]
            if (wb_wr && hit_aux)
                aux_r <= wbyte;
        end
    end

    // Interrupt enables and event mask.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ictrl_r <= CMP_ICTRL_RST;
            imask_r <= CMP_EV_RESET;
        end
        else
        begin
            if (wb_wr && hit_ic)
                ictrl_r <= wbyte[CMP_ICTRL_W-1:0];
            if (wb_wr && hit_im)
                imask_r <= wbyte[CMP_EV_W-1:0];
        end
    end

    // Sticky events, cleared by writing one; a new event wins.
    wire [CMP_EV_W-1:0] ev_set;
    wire [CMP_EV_W-1:0] ev_clr = (wb_wr && hit_is) ? wbyte[CMP_EV_W-1:0] : CMP_EV_RESET;
    assign ev_set[CMP_EV_CHANGE] = change_ev;
    assign ev_set[CMP_EV_WAKE]   = state_r[1] && (state_nxt == CMP_POSTWAKE);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            istat_r <= CMP_EV_RESET;
        else
            istat_r <= ev_set | (istat_r & ~ev_clr);
    end

    // =====================================================================
    // Core sequencing across Sleep
    // =====================================================================
    wire cie    = ictrl_r[CMP_ICTRL_CIE];
    wire per_en = ictrl_r[CMP_ICTRL_PER];
    wire glb_en = ictrl_r[CMP_ICTRL_GLB];
    wire wake   = flag_r && cie && per_en; // [R7]
    wire vector = wake && glb_en;

    // Next state of the core sequencer.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CMP_RUN:
            begin
                if (sleep_req && !wake)
                    state_nxt = CMP_SLEEP;
            end
            CMP_SLEEP:
            begin
                if (wake)
                    state_nxt = CMP_POSTWAKE; // [R7]
            end
            CMP_POSTWAKE:
            begin
                if (instr_done)
                    state_nxt = glb_en ? CMP_VECTOR : CMP_RUN; // [R8] [R9]
            end
            CMP_VECTOR:
            begin
                state_nxt = CMP_RUN;
            end
            default:
            begin
                state_nxt = CMP_RUN;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_r <= CMP_RUN;
        else
            state_r <= state_nxt;
    end

    // =====================================================================
    // Bus answer
    // =====================================================================
    // Read multiplexer; unmapped offsets read zero.
    wire [7:0] rd_byte = hit_cfg ? cfg_view :
                         hit_aux ? aux_r :
                         hit_pf  ? {7'h00, flag_r} :
                         hit_ic  ? {5'h00, ictrl_r} :
                         hit_is  ? {6'h00, istat_r} :
                         hit_im  ? {6'h00, imask_r} :
                         hit_st  ? {5'h00, mismatch, comp_en_r, sleeping_r} :
                                   8'h00;

    // One wait state, then ack for a single cycle.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r  <= wb_req;
            rdat_r <= wb_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // =====================================================================
    // Registered outputs
    // =====================================================================
    // Analog control follows the mode; the reset mode forces analog pins.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            comp_en_r    <= 1'b0;
            pin_analog_r <= 1'b1;
            switch_r     <= 1'b0;
            pol_r        <= 1'b0;
            result_r     <= 1'b0;
        end
        else
        begin
            comp_en_r    <= !mode_off; // [R6] [R11]
            pin_analog_r <= mode_reset; // [R11]
            switch_r     <= cfg_r[CMP_CFG_SWITCH];
            pol_r        <= cfg_r[CMP_CFG_POL];
            result_r     <= sample_r;
        end
    end

    // Core handshake, interrupt request and interrupt line.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sleeping_r  <= 1'b0;
            exec_next_r <= 1'b0;
            vector_r    <= 1'b0;
            isr_req_r   <= 1'b0;
            irq_r       <= 1'b0;
        end
        else
        begin
            sleeping_r  <= (state_nxt == CMP_SLEEP);
            exec_next_r <= (state_nxt == CMP_POSTWAKE); // [R8]
            vector_r    <= (state_nxt == CMP_VECTOR); // [R9]
            isr_req_r   <= vector && (state_nxt == CMP_RUN);
            irq_r       <= |((ev_set | (istat_r & ~ev_clr)) & imask_r);
        end
    end

    assign wb_ack_o            = ack_r;
    assign wb_dat_o            = rdat_r;
    assign comparator_enable   = comp_en_r;
    assign pin_analog          = pin_analog_r;
    assign input_switch_select = switch_r;
    assign output_polarity     = pol_r;
    assign comparator_result   = result_r;
    assign sleeping            = sleeping_r;
    assign exec_next           = exec_next_r;
    assign vector_isr          = vector_r;
    assign isr_req             = isr_req_r;
    assign irq                 = irq_r;

endmodule

// ### tb/cmp_sleep_ctrl_props.sv
// Concurrent checks on the ports of the comparator sleep and reset controller.
`timescale 1ns/1ps

module cmp_sleep_ctrl_props
    import cmp_pkg::*;
#(
    parameter int unsigned Q_PHASES = 4
)
(
    // Clock and reset.
    input wire logic                          clk,
    input wire logic                          rstn,
    // Register bus.
    input wire logic                          wb_cyc_i,
    input wire logic                          wb_stb_i,
    input wire logic                          wb_we_i,
    input wire logic [cmp_pkg::CMP_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]                    wb_sel_i,
    input wire logic [cmp_pkg::CMP_DAT_W-1:0] wb_dat_i,
    input wire logic [cmp_pkg::CMP_DAT_W-1:0] wb_dat_o,
    input wire logic                          wb_ack_o,
    // Comparator and core side.
    input wire logic                          comparator_enable,
    input wire logic                          pin_analog,
    input wire logic                          instr_done,
    input wire logic                          sleeping,
    input wire logic                          exec_next,
    input wire logic                          vector_isr
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // =====================================================================
    // Request decode at the taking edge
    wire logic take_w   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic cfg_w    = take_w && (wb_adr_i == CMP_OFF_CONFIG);
    wire logic cfg_wr_w = cfg_w && wb_we_i && wb_sel_i[0];
    wire logic off_w    = (wb_dat_i[2:0] == CMP_MODE_OFF_A) || (wb_dat_i[2:0] == CMP_MODE_OFF_B);

    // =====================================================================
    // Assertions
    ack_latency_a: assert property (take_w |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    cfg_zero_bits_a: assert property (cfg_w && !wb_we_i |=> !wb_dat_o[5]
        && wb_dat_o[31:7] == 25'h0) else $error("config zero bits set");
    mode_off_a: assert property (cfg_wr_w && off_w |-> ##2 !comparator_enable)
        else $error("enabled in off mode");
    mode_on_a: assert property (cfg_wr_w && !off_w |-> ##2 !pin_analog
        && comparator_enable) else $error("not enabled in active mode");
    reset_mode_a: assert property (cfg_wr_w && wb_dat_i[2:0] == 3'h0 |-> ##2 pin_analog)
        else $error("pins not analog");
    reset_out_a: assert property ($rose(rstn) |-> pin_analog && !comparator_enable)
        else $error("not reset mode after reset");
    wake_entry_a: assert property ($fell(sleeping) |-> exec_next)
        else $error("wake without post-wake step");
    post_hold_a: assert property (exec_next && !instr_done |=> exec_next && !sleeping)
        else $error("post-wake step skipped");
    vector_cause_a: assert property (vector_isr |-> $past(exec_next) && $past(instr_done))
        else $error("vector without post-wake step");
    vector_pulse_a: assert property (vector_isr |=> !vector_isr)
        else $error("vector too long");
endmodule

bind cmp_sleep_ctrl cmp_sleep_ctrl_props #(.Q_PHASES(Q_PHASES)) props_u (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .comparator_enable(comparator_enable), .pin_analog(pin_analog),
    .instr_done(instr_done), .sleeping(sleeping), .exec_next(exec_next),
    .vector_isr(vector_isr));

// ### tb/cmp_sleep_ctrl_tb.sv
// Self-checking bench for the comparator sleep and reset controller.
`timescale 1ns/1ps

module cmp_sleep_ctrl_tb;
    import cmp_pkg::*;

    // =====================================================================
    // Signals and counters
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'hF;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic        ack, cen, pan, isw, pol, res, slp, exn, vec, isr, irq;
    logic        raw = 1'b0;
    logic        sleep_req = 1'b0;
    logic        instr_done = 1'b0;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cyc_cnt = 0;

    // Clock of 8 ns period.
    always #4 clk = ~clk;

    cmp_sleep_ctrl #(.Q_PHASES(4)) dut_u (
        .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .comparator_raw(raw), .comparator_enable(cen), .pin_analog(pan),
        .input_switch_select(isw), .output_polarity(pol), .comparator_result(res),
        .sleep_req(sleep_req), .instr_done(instr_done), .sleeping(slp), .exec_next(exn),
        .vector_isr(vec), .isr_req(isr), .irq(irq));

    // =====================================================================
    // Shared tasks
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Hold the request until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        chk("wb_ack_o", 32'h1, 32'(ack));
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_reset;
        chk("pin_analog", 32'h1, 32'(pan));
        chk("comparator_enable", 32'h0, 32'(cen));
        rd("config", CMP_OFF_CONFIG, 32'h0);
        rd("aux", CMP_OFF_AUX, 32'h0);
        wr(8'h40, 32'h0000_00FF);
        rd("unmapped", 8'h40, 32'h0);
    endtask

    // Every mode, then all writable bits, then settle in an active mode.
    task automatic t_modes;
        for (int m = 0; m < 8; m++)
        begin
            wr(CMP_OFF_CONFIG, 32'(m));
            tick(2);
            chk("comparator_enable", 32'(m != 0 && m != 7), 32'(cen));
            chk("pin_analog", 32'(m == 0), 32'(pan));
        end
        wr(CMP_OFF_CONFIG, 32'h0000_00FF);
        rd("config layout", CMP_OFF_CONFIG, 32'h0000_001F);
        chk("input_switch_select", 32'h1, 32'(isw));
        wr(CMP_OFF_CONFIG, 32'h0000_0002);
        tick(125);
        rd("config", CMP_OFF_CONFIG, 32'h0000_0002);
        wr(CMP_OFF_PFLAG, 32'h0);
        wr(CMP_OFF_ISTAT, 32'h3);
    endtask

    task automatic t_change;
        raw <= 1'b1;
        tick(12);
        rd("change flag", CMP_OFF_PFLAG, 32'h1);
        wr(CMP_OFF_PFLAG, 32'h0);
        rd("flag under mismatch", CMP_OFF_PFLAG, 32'h1);
        rd("config result", CMP_OFF_CONFIG, 32'h0000_0042);
        wr(CMP_OFF_PFLAG, 32'h0);
        rd("flag cleared", CMP_OFF_PFLAG, 32'h0);
        chk("comparator_result", 32'h1, 32'(res));
        wr(CMP_OFF_CONFIG, 32'h0000_0012);
        tick(8);
        rd("inverted result", CMP_OFF_CONFIG, 32'h0000_0012);
        chk("output_polarity", 32'h1, 32'(pol));
        wr(CMP_OFF_PFLAG, 32'h0);
        wr(CMP_OFF_ISTAT, 32'h3);
    endtask

    task automatic t_irq;
        wr(CMP_OFF_IMASK, 32'h1);
        raw <= 1'b0;
        tick(12);
        chk("irq", 32'h1, 32'(irq));
        rd("event status", CMP_OFF_ISTAT, 32'h1);
        wr(CMP_OFF_IMASK, 32'h0);
        tick(2);
        chk("irq masked", 32'h0, 32'(irq));
        wr(CMP_OFF_IMASK, 32'h1);
        wr(CMP_OFF_ISTAT, 32'h1);
        tick(2);
        chk("irq cleared", 32'h0, 32'(irq));
        rd("config reload", CMP_OFF_CONFIG, 32'h0000_0052);
        wr(CMP_OFF_PFLAG, 32'h0);
        rd("flag after reload", CMP_OFF_PFLAG, 32'h0);
    endtask

    // Sleep, change the comparator, wake by enables, finish the next instruction.
    task automatic t_sleep(input logic [2:0] en);
        logic v = 1'b0;
        int   n = 0;
        wr(CMP_OFF_ICTRL, 32'(en));
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        raw <= ~raw;
        tick(20);
        chk("sleeping", 32'(!(en[0] && en[1])), 32'(slp));
        wr(CMP_OFF_ICTRL, 32'(en | 3'h3));
        while (exn !== 1'b1 && n < 30)
        begin
            @(posedge clk);
            n++;
        end
        tick(3);
        chk("exec_next", 32'h1, 32'(exn));
        chk("sleeping", 32'h0, 32'(slp));
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
        repeat (4)
        begin
            @(posedge clk);
            v = v | vec;
        end
        chk("vector_isr", 32'(en[2]), 32'(v));
        chk("isr_req", 32'(en[2]), 32'(isr));
        chk("exec_next done", 32'h0, 32'(exn));
        rd("events", CMP_OFF_ISTAT, 32'h3);
        rd("status", CMP_OFF_STATUS, 32'h6);
        rd("config", CMP_OFF_CONFIG, {25'h0, ~raw, 6'h12});
        wr(CMP_OFF_PFLAG, 32'h0);
        wr(CMP_OFF_ICTRL, 32'h0);
        wr(CMP_OFF_ISTAT, 32'h3);
    endtask

    task automatic t_rst;
        wr(CMP_OFF_CONFIG, 32'h0000_001A);
        wr(CMP_OFF_AUX, 32'h0000_0055);
        rd("aux", CMP_OFF_AUX, 32'h0000_0055);
        rstn <= 1'b0;
        tick(3);
        rstn <= 1'b1;
        rd("config after reset", CMP_OFF_CONFIG, 32'h0);
        rd("aux after reset", CMP_OFF_AUX, 32'h0);
        chk("pin_analog", 32'h1, 32'(pan));
    endtask

    // Main sequence after ten cycles of reset.
    initial
    begin
        tick(10);
        rstn <= 1'b1;
        t_reset;
        t_modes;
        t_change;
        t_irq;
        t_sleep(3'h3);
        t_sleep(3'h7);
        t_sleep(3'h2);
        t_rst;
        results;
    end

    // Timeout well above the expected run length.
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 5000)
        begin
            n_errors++;
            results;
        end
    end
endmodule
